// file: dual_mode_compare_timer_map.svh
// register map, field positions, reset values of the compare timer
`ifndef DUAL_MODE_COMPARE_TIMER_MAP_SVH
`define DUAL_MODE_COMPARE_TIMER_MAP_SVH
`define TMR_ADDR_CTRL 16'hFFB6
`define TMR_ADDR_STAT 16'hFFB7
`define TMR_ADDR_CNTH 16'hFFB8
`define TMR_ADDR_CNTL 16'hFFB9
`define TMR_ADDR_CMPH 16'hFFBA
`define TMR_ADDR_CMPL 16'hFFBB
`define TMR_CTRL_LVLH 7
`define TMR_CTRL_MSBH 6
`define TMR_CTRL_LVLL 3
`define TMR_CTRL_MSBL 2
`define TMR_STAT_HIGH_OVERFLOW_FLAG 7
`define TMR_STAT_HIGH_MATCH_FLAG 6
`define TMR_STAT_HIGH_OVERFLOW_IRQ_ENABLE 5
`define TMR_STAT_HIGH_CLEAR_ON_MATCH 4
`define TMR_STAT_LOW_OVERFLOW_FLAG 3
`define TMR_STAT_LOW_MATCH_FLAG 2
`define TMR_STAT_LOW_OVERFLOW_IRQ_ENABLE 1
`define TMR_STAT_LOW_CLEAR_ON_MATCH 0
`define TMR_STAT_FLAGS 8'hCC
`define TMR_CTRL_RST 8'h00
`define TMR_STAT_RST 8'h00
`define TMR_CNT_RST 8'h00
`define TMR_CMP_RST 8'hFF
`define TMR_WO_READ 8'hFF
`define TMR_UNMAPPED_READ 8'h00
`define TMR_PRESC_W 5
`endif

// file: dual_mode_compare_timer_pkg.sv
// types of the compare timer
package dual_mode_compare_timer_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic highOutLevel;
    logic [2:0] highClockSelect;
    logic lowOutLevel;
    logic [2:0] lowClockSelect;
  } ctrl_t;
  typedef struct packed {
    logic high;
    logic low;
  } pair_t;
endpackage

// file: dual_mode_compare_timer.sv
// dual 8-bit or cascaded 16-bit up-counter with compare, toggle outputs and flags
// Operation
// (RULE_01) 16-bit up-counter of two cascaded 8-bit halves, or two independent halves
// (RULE_02) reset clears both counter halves to zero
// (RULE_03) reset sets both compare halves to all ones
// (RULE_04) high select msb 0 gives 16-bit mode, 1 gives two 8-bit timers
// (RULE_05) 16-bit mode: high half counts low overflows, low select clocks all
// (RULE_06) 8-bit mode high clock codes 100..111 give clk/32, /16, /4, /2
// (RULE_07) low clock: event pin when msb 0, else clk/32, /16, /4, /2
// (RULE_08) event counting uses rising or falling edge per outside edge select
// (RULE_09) 16-bit wrap sets high overflow flag, request when enable set
// (RULE_10) 8-bit wrap of each half sets own overflow flag and gated request
// (RULE_11) 16-bit compare equality sets high match flag and high request
// (RULE_12) 8-bit mode each half compared, match sets own flag and request
// (RULE_13) each half cleared on match per own clear bit; high bit in 16-bit mode
// (RULE_14) high toggle inverts per high match; low toggle per low match, 8-bit mode
// (RULE_15) writing output level bits drives toggle pins to that level at once
// (RULE_16) control register is write-only, holds levels and selects, resets zero
// (RULE_17) 16-bit mode counter and compare transfers pass through a byte latch
// (RULE_18) software avoids changing event pin function while the pin is low
// (RULE_19) upper byte first: write latches, low write commits, high read captures low
// (RULE_20) flags cleared only by writing 0 after reading 1, never set by software
// (RULE_21) 16-bit mode high clear bit clears whole counter on 16-bit match
`timescale 1ns/1ps
`include "dual_mode_compare_timer_map.svh"
module dual_mode_compare_timer
  import dual_mode_compare_timer_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // cpu byte bus
  input wire bus_req_t busReq,
  output logic [7:0] busRdata,
  // event pin and its edge select
  input wire logic eventInputPin,
  input wire logic eventEdgeSelect,
  // toggle pins
  output logic highToggleOut,
  output logic lowToggleOut,
  // interrupt request set pulses
  output logic highIrqRequest,
  output logic lowIrqRequest
);

  // prescaler tick for a two-bit divider code
  function automatic logic divTick(input logic [1:0] sel,
                                   input logic [`TMR_PRESC_W-1:0] p);
    unique case (sel)
      2'b00: divTick = &p[4:0];
      2'b01: divTick = &p[3:0];
      2'b10: divTick = &p[1:0];
      2'b11: divTick = p[0];
    endcase
  endfunction

  logic [`TMR_PRESC_W-1:0] presc_r;
  ctrl_t ctrl_r;
  logic [7:0] stat_r;
  logic [7:0] statArm_r;
  logic [7:0] cntH_r;
  logic [7:0] cntL_r;
  logic [7:0] cmpH_r;
  logic [7:0] cmpL_r;
  logic [7:0] temp_r;
  logic eventPrev_r;
  pair_t matchPrev_r;
  logic [7:0] cntH_nxt;
  logic [7:0] cntL_nxt;
  logic [7:0] stat_nxt;

  // address decode
  wire wrCtrl = busReq.wr && busReq.addr == `TMR_ADDR_CTRL;
  wire wrStat = busReq.wr && busReq.addr == `TMR_ADDR_STAT;
  wire wrCntH = busReq.wr && busReq.addr == `TMR_ADDR_CNTH;
  wire wrCntL = busReq.wr && busReq.addr == `TMR_ADDR_CNTL;
  wire wrCmpH = busReq.wr && busReq.addr == `TMR_ADDR_CMPH;
  wire wrCmpL = busReq.wr && busReq.addr == `TMR_ADDR_CMPL;
  wire rdStat = busReq.rd && busReq.addr == `TMR_ADDR_STAT;
  wire rdCntH = busReq.rd && busReq.addr == `TMR_ADDR_CNTH;

  // mode and clock selection
  wire mode8 = ctrl_r.highClockSelect[2]; // RULE_04
  wire eventEdge = eventEdgeSelect ? (eventInputPin && !eventPrev_r)
                                   : (!eventInputPin && eventPrev_r); // RULE_08
  wire lowTick = ctrl_r.lowClockSelect[2] ? divTick(ctrl_r.lowClockSelect[1:0], presc_r)
                                          : eventEdge; // RULE_07
  wire lowWrap = lowTick && cntL_r == 8'hFF;
  wire highTick = mode8 ? divTick(ctrl_r.highClockSelect[1:0], presc_r) // RULE_06
                        : lowWrap; // RULE_05
  wire highWrap = highTick && cntH_r == 8'hFF;

  // compare
  wire eqH = cntH_r == cmpH_r;
  wire eqL = cntL_r == cmpL_r;
  wire matchH = mode8 ? eqH : (eqH && eqL); // RULE_11
  wire matchL = mode8 && eqL; // RULE_12
  wire matchEvH = matchH && !matchPrev_r.high;
  wire matchEvL = matchL && !matchPrev_r.low;
  wire clrH = matchEvH && stat_r[`TMR_STAT_HIGH_CLEAR_ON_MATCH]; // RULE_13
  wire clrL = mode8 ? (matchEvL && stat_r[`TMR_STAT_LOW_CLEAR_ON_MATCH])
                    : clrH; // RULE_21
  wire ovfSetH = highWrap; // RULE_09
  wire ovfSetL = mode8 && lowWrap; // RULE_10

  // counter next values; cpu write beats counting
  always_comb begin
    cntL_nxt = cntL_r;
    if (clrL) begin
      cntL_nxt = `TMR_CNT_RST;
    end else if (lowTick) begin
      cntL_nxt = cntL_r + 8'h01; // RULE_01
    end
    if ((wrCntL && !mode8) || (wrCntL && mode8)) begin
      cntL_nxt = busReq.wdata;
    end
    cntH_nxt = cntH_r;
    if (clrH) begin
      cntH_nxt = `TMR_CNT_RST;
    end else if (highTick) begin
      cntH_nxt = cntH_r + 8'h01; // RULE_01
    end
    if (wrCntH && mode8) begin
      cntH_nxt = busReq.wdata;
    end else if (wrCntL && !mode8) begin
      cntH_nxt = temp_r; // RULE_19
    end
  end

  // status next value; hardware set wins over software clear
  wire [7:0] flagSet = {ovfSetH, matchEvH, 2'b00, ovfSetL, matchEvL, 2'b00};
  wire [7:0] flagClr = wrStat ? (statArm_r & ~busReq.wdata & `TMR_STAT_FLAGS)
                              : 8'h00; // RULE_20
  always_comb begin
    stat_nxt = stat_r & ~flagClr;
    if (wrStat) begin
      stat_nxt = (stat_nxt & `TMR_STAT_FLAGS) | (busReq.wdata & ~`TMR_STAT_FLAGS);
    end
    stat_nxt = stat_nxt | flagSet;
  end

  // read mux
  logic [7:0] rdMux;
  always_comb begin
    unique case (busReq.addr)
      `TMR_ADDR_CTRL: rdMux = `TMR_WO_READ; // RULE_16
      `TMR_ADDR_STAT: rdMux = stat_r;
      `TMR_ADDR_CNTH: rdMux = cntH_r;
      `TMR_ADDR_CNTL: rdMux = mode8 ? cntL_r : temp_r; // RULE_17
      `TMR_ADDR_CMPH: rdMux = cmpH_r;
      `TMR_ADDR_CMPL: rdMux = cmpL_r;
      default: rdMux = `TMR_UNMAPPED_READ;
    endcase
  end

  // prescaler and pin history
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      presc_r <= '0;
      eventPrev_r <= 1'b0;
      matchPrev_r <= '0;
    end else begin
      presc_r <= presc_r + 5'd1;
      eventPrev_r <= eventInputPin;
      matchPrev_r <= '{high: matchH, low: matchL};
    end
  end

  // control register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r <= `TMR_CTRL_RST; // RULE_16
    end else if (wrCtrl) begin
      ctrl_r <= busReq.wdata;
    end
  end

  // counters
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cntH_r <= `TMR_CNT_RST; // RULE_02
      cntL_r <= `TMR_CNT_RST; // RULE_02
    end else begin
      cntH_r <= cntH_nxt;
      cntL_r <= cntL_nxt;
    end
  end

  // compare registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmpH_r <= `TMR_CMP_RST; // RULE_03
      cmpL_r <= `TMR_CMP_RST; // RULE_03
    end else begin
      if (wrCmpH && mode8) begin
        cmpH_r <= busReq.wdata;
      end else if (wrCmpL && !mode8) begin
        cmpH_r <= temp_r; // RULE_17
      end
      if (wrCmpL) begin
        cmpL_r <= busReq.wdata;
      end
    end
  end

  // byte latch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      temp_r <= 8'h00;
    end else if (!mode8 && (wrCntH || wrCmpH)) begin
      temp_r <= busReq.wdata; // RULE_19
    end else if (!mode8 && rdCntH) begin
      temp_r <= cntL_r; // RULE_19
    end
  end

  // status and read arming
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stat_r <= `TMR_STAT_RST;
      statArm_r <= 8'h00;
    end else begin
      stat_r <= stat_nxt;
      if (rdStat) begin
        statArm_r <= stat_r & `TMR_STAT_FLAGS;
      end else if (wrStat) begin
        statArm_r <= 8'h00;
      end
    end
  end

  // toggle outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      highToggleOut <= 1'b0;
      lowToggleOut <= 1'b0;
    end else if (wrCtrl) begin
      highToggleOut <= busReq.wdata[`TMR_CTRL_LVLH]; // RULE_15
      lowToggleOut <= busReq.wdata[`TMR_CTRL_LVLL]; // RULE_15
    end else begin
      if (matchEvH) begin
        highToggleOut <= !highToggleOut; // RULE_14
      end
      if (matchEvL) begin
        lowToggleOut <= !lowToggleOut; // RULE_14
      end
    end
  end

  // read data and request pulses
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busRdata <= 8'h00;
      highIrqRequest <= 1'b0;
      lowIrqRequest <= 1'b0;
    end else begin
      if (busReq.rd) begin
        busRdata <= rdMux;
      end
      highIrqRequest <= matchEvH || (ovfSetH && stat_r[`TMR_STAT_HIGH_OVERFLOW_IRQ_ENABLE]); // RULE_09
      lowIrqRequest <= matchEvL || (ovfSetL && stat_r[`TMR_STAT_LOW_OVERFLOW_IRQ_ENABLE]); // RULE_10
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_wrap16;
    !mode8 && cntH_r == 8'hFF && cntL_r == 8'hFF && lowTick && !busReq.wr
      && !clrH |=> cntH_r == 8'h00 && cntL_r == 8'h00 && stat_r[`TMR_STAT_HIGH_OVERFLOW_FLAG];
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit wrap wrong"); // RULE_09

  property p_cascade;
    !mode8 && !busReq.wr && !clrL && lowTick && cntL_r != 8'hFF
      |=> $stable(cntH_r);
  endproperty
  a_cascade: assert property (p_cascade) else $error("high moved alone"); // RULE_05

  property p_div2;
    mode8 && ctrl_r.highClockSelect[1:0] == 2'b11 && !busReq.wr && !clrH
      && presc_r[0] |=> cntH_r == $past(cntH_r) + 8'h01;
  endproperty
  a_div2: assert property (p_div2) else $error("div2 tick missed"); // RULE_06

  property p_ovf8l;
    mode8 && lowWrap && stat_r[`TMR_STAT_LOW_OVERFLOW_IRQ_ENABLE] |=> stat_r[`TMR_STAT_LOW_OVERFLOW_FLAG]
      && lowIrqRequest;
  endproperty
  a_ovf8l: assert property (p_ovf8l) else $error("low overflow lost"); // RULE_10

  property p_match16;
    !mode8 && matchEvH && !wrCtrl |=> stat_r[`TMR_STAT_HIGH_MATCH_FLAG] && highIrqRequest
      && highToggleOut != $past(highToggleOut);
  endproperty
  a_match16: assert property (p_match16) else $error("16-bit match lost"); // RULE_11

  property p_clr16;
    !mode8 && matchEvH && stat_r[`TMR_STAT_HIGH_CLEAR_ON_MATCH] && !busReq.wr
      |=> cntH_r == 8'h00 && cntL_r == 8'h00;
  endproperty
  a_clr16: assert property (p_clr16) else $error("16-bit clear missed"); // RULE_21

  property p_level;
    wrCtrl |=> highToggleOut == $past(busReq.wdata[7])
      && lowToggleOut == $past(busReq.wdata[3]);
  endproperty
  a_level: assert property (p_level) else $error("level write ignored"); // RULE_15

  property p_noswset;
    wrStat && !ovfSetH && !stat_r[`TMR_STAT_HIGH_OVERFLOW_FLAG] |=> !stat_r[`TMR_STAT_HIGH_OVERFLOW_FLAG];
  endproperty
  a_noswset: assert property (p_noswset) else $error("flag set by write"); // RULE_20

  property p_unarmed;
    wrStat && !statArm_r[`TMR_STAT_HIGH_MATCH_FLAG] && stat_r[`TMR_STAT_HIGH_MATCH_FLAG]
      |=> stat_r[`TMR_STAT_HIGH_MATCH_FLAG];
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("clear without read"); // RULE_20

  property p_commit;
    (!mode8 && wrCntH) ##1 (!busReq.wr && !busReq.rd) ##1 (wrCntL && !mode8)
      |=> cntH_r == $past(busReq.wdata, 3) && cntL_r == $past(busReq.wdata);
  endproperty
  a_commit: assert property (p_commit) else $error("pair write wrong"); // RULE_19

  property p_match8l;
    mode8 && matchEvL && !busReq.wr |=> stat_r[`TMR_STAT_LOW_MATCH_FLAG] && lowIrqRequest
      && lowToggleOut != $past(lowToggleOut);
  endproperty
  a_match8l: assert property (p_match8l) else $error("8-bit low match lost"); // RULE_12

  property p_clr8l;
    mode8 && matchEvL && stat_r[`TMR_STAT_LOW_CLEAR_ON_MATCH] && !busReq.wr |=> cntL_r == 8'h00;
  endproperty
  a_clr8l: assert property (p_clr8l) else $error("8-bit low clear missed"); // RULE_13

  property p_evcount;
    !ctrl_r.lowClockSelect[2] && eventEdge && !busReq.wr && !clrL && cntL_r != 8'hFF
      |=> cntL_r == $past(cntL_r) + 8'h01;
  endproperty
  a_evcount: assert property (p_evcount) else $error("event not counted"); // RULE_08

  c_wrap16: cover property (!mode8 && highWrap);
  c_match8: cover property (mode8 && matchEvL);
  c_event: cover property (!ctrl_r.lowClockSelect[2] && eventEdge);
  c_flagclr: cover property (|flagClr);

endmodule

// file: dual_mode_compare_timer_partner.sv
// event pin source facing the compare timer
`timescale 1ns/1ps
module event_source_model (
  // clock
  input wire logic clk_sys,
  // event pin
  output logic eventInputPin
);
  initial eventInputPin = 1'b0;
  // each level held two cycles; pin function never switched
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1 eventInputPin = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 eventInputPin = 1'b0;
      @(posedge clk_sys);
    end
  endtask
endmodule

// file: dual_mode_compare_timer_tb.sv
// self-checking bench of the compare timer
`timescale 1ns/1ps
`include "dual_mode_compare_timer_map.svh"
module dual_mode_compare_timer_tb
  import dual_mode_compare_timer_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  bus_req_t busReq = '0;
  logic [7:0] busRdata;
  logic eventEdgeSelect = 1'b1;
  logic eventInputPin;
  logic highToggleOut;
  logic lowToggleOut;
  logic highIrqRequest;
  logic lowIrqRequest;
  logic [7:0] rv;
  int miscompares = 0;
  int total_checks = 0;
  int highIrqs = 0;
  int lowIrqs = 0;

  always #5 clk_sys = ~clk_sys;

  // count request pulses away from the launching edge
  always @(negedge clk_sys) begin
    if (highIrqRequest === 1'b1) highIrqs++;
    if (lowIrqRequest === 1'b1) lowIrqs++;
  end

  dual_mode_compare_timer uut (
    .clk_sys(clk_sys),
    .rst(rst),
    .busReq(busReq),
    .busRdata(busRdata),
    .eventInputPin(eventInputPin),
    .eventEdgeSelect(eventEdgeSelect),
    .highToggleOut(highToggleOut),
    .lowToggleOut(lowToggleOut),
    .highIrqRequest(highIrqRequest),
    .lowIrqRequest(lowIrqRequest)
  );

  event_source_model ev (
    .clk_sys(clk_sys),
    .eventInputPin(eventInputPin)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 busReq = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    #1 busReq.wr = 1'b0;
  endtask

  task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    #1 busReq = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    #1 busReq.rd = 1'b0;
    rv = busRdata;
    check(what, rv, exp);
  endtask

  task automatic test_reset;
    rchk("stat", `TMR_ADDR_STAT, 8'h00);
    rchk("cnth", `TMR_ADDR_CNTH, 8'h00);
    rchk("cntl", `TMR_ADDR_CNTL, 8'h00);
    rchk("cmph", `TMR_ADDR_CMPH, 8'hFF);
    rchk("cmpl", `TMR_ADDR_CMPL, 8'hFF);
    rchk("ctrl", `TMR_ADDR_CTRL, 8'hFF);
    rchk("unmapped", 16'hFFBC, 8'h00);
    check("tog", {6'h00, highToggleOut, lowToggleOut}, 8'h00);
  endtask

  task automatic test_latch;
    wr(`TMR_ADDR_CMPH, 8'hAA);
    rchk("lone", `TMR_ADDR_CMPH, 8'hFF);
    wr(`TMR_ADDR_CMPL, 8'h55);
    rchk("cmph2", `TMR_ADDR_CMPH, 8'hAA);
    rchk("cmpl2", `TMR_ADDR_CMPL, 8'h55);
    wr(`TMR_ADDR_CNTH, 8'h12);
    wr(`TMR_ADDR_CNTL, 8'h34);
  endtask

  task automatic test_events;
    ev.pulses(3);
    #1 eventEdgeSelect = 1'b0;
    ev.pulses(2);
    repeat (2) @(posedge clk_sys);
    rchk("evh", `TMR_ADDR_CNTH, 8'h12);
    rchk("evl", `TMR_ADDR_CNTL, 8'h39);
  endtask

  task automatic test_match8;
    eventEdgeSelect = 1'b1;
    wr(`TMR_ADDR_CTRL, 8'hC8);
    @(posedge clk_sys);
    #1 check("lvl", {6'h00, highToggleOut, lowToggleOut}, 8'h03);
    wr(`TMR_ADDR_CMPL, 8'h02);
    wr(`TMR_ADDR_CNTL, 8'h00);
    wr(`TMR_ADDR_STAT, 8'h01);
    ev.pulses(2);
    repeat (3) @(posedge clk_sys);
    check("lirq", 8'(lowIrqs), 8'h01);
    check("ltog", {7'h00, lowToggleOut}, 8'h00);
    rchk("clr", `TMR_ADDR_CNTL, 8'h00);
    wr(`TMR_ADDR_STAT, 8'h01);
    rchk("unarmed", `TMR_ADDR_STAT, 8'h05);
    wr(`TMR_ADDR_STAT, 8'h01);
    rchk("cleared", `TMR_ADDR_STAT, 8'h01);
  endtask

  task automatic test_ovf16;
    wr(`TMR_ADDR_CTRL, 8'h07);
    wr(`TMR_ADDR_STAT, 8'hEC);
    rchk("noset", `TMR_ADDR_STAT, 8'h20);
    wr(`TMR_ADDR_CNTH, 8'hFF);
    wr(`TMR_ADDR_CNTL, 8'hF0);
    repeat (40) @(posedge clk_sys);
    check("hirq", 8'(highIrqs), 8'h01);
    rchk("high_overflow_flag", `TMR_ADDR_STAT, 8'hA0);
    rchk("wrap", `TMR_ADDR_CNTH, 8'h00);
  endtask

  task automatic test_match16;
    wr(`TMR_ADDR_CTRL, 8'h00);
    wr(`TMR_ADDR_STAT, 8'h10);
    wr(`TMR_ADDR_CNTH, 8'h00);
    wr(`TMR_ADDR_CNTL, 8'h00);
    wr(`TMR_ADDR_CMPH, 8'h00);
    wr(`TMR_ADDR_CMPL, 8'h03);
    ev.pulses(3);
    repeat (2) @(posedge clk_sys);
    check("hirq16", 8'(highIrqs), 8'h02);
    check("htog", {7'h00, highToggleOut}, 8'h01);
    rchk("high_match_flag", `TMR_ADDR_STAT, 8'h50);
    rchk("clr16h", `TMR_ADDR_CNTH, 8'h00);
    rchk("clr16l", `TMR_ADDR_CNTL, 8'h00);
  endtask

  task automatic test_div8;
    wr(`TMR_ADDR_CMPH, 8'hFF);
    wr(`TMR_ADDR_CMPL, 8'hFF);
    wr(`TMR_ADDR_CTRL, 8'h70);
    wr(`TMR_ADDR_CNTH, 8'h00);
    repeat (14) @(posedge clk_sys);
    wr(`TMR_ADDR_CTRL, 8'h00);
    rchk("div2", `TMR_ADDR_CNTH, 8'h08);
  endtask

  task automatic test_ovf8;
    wr(`TMR_ADDR_CTRL, 8'h40);
    wr(`TMR_ADDR_STAT, 8'h02);
    wr(`TMR_ADDR_CNTL, 8'hFE);
    ev.pulses(2);
    repeat (2) @(posedge clk_sys);
    check("lirq8", 8'(lowIrqs), 8'h03);
    check("ltog8", {7'h00, lowToggleOut}, 8'h01);
    rchk("low_overflow_flag", `TMR_ADDR_STAT, 8'h0E);
  endtask

  task automatic summarize;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rst = 1'b0;
    test_reset;
    test_latch;
    test_events;
    test_match8;
    test_ovf16;
    test_match16;
    test_div8;
    test_ovf8;
    summarize;
  end

  // watchdog well past the expected run
  initial begin
    #100000;
    miscompares++;
    summarize;
  end
endmodule
